// ### timer_channel.sv
// How it works
// - Edge field bits 7:6, code 00 falling edge valid, 01 rising edge valid.
// - Code 10 both edges: start on falling, capture on following rising.
// - Code 11 both edges: start on rising, capture on following falling.
// - Mode 000 interval, 011 event counter, 100 one-count all count down.
// - Mode 010 capture measures pulse interval, counter counts up.
// - Mode 110 capture and one-count measures level width, counts up.
// - Interval or capture: option 1 gives start interrupt and output change.
// - Event counter: option kept 0, no start interrupt, output unchanged.
// - One-count: option 1 makes retrigger restart with interrupt, else ignored.
// - Capture one-count: no start interrupt, output kept, retriggers ignored.
// - Interrupt recurs every compare value plus one count clock periods.
// - Output mode bit 1 selects master when 0, slave when 1.
// - Output level bit 1 gives active high when 0, active low when 1.
// - Output value bit 1 shows the current timer output level.
// - Trigger source 000 software only, 001 valid pin edge starts and captures.
// - Output disabled: software writes set pin; enabled: waveform drives, writes ignored.
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
module timer_channel (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_input_pin,
  output logic timer_output,
  output logic channel_interrupt
);
  typedef struct packed {
    logic [15:0] mode;
    logic [15:0] compare;
    logic tom;
    logic tol;
    logic toe;
    logic tout;
    logic [15:0] cnt;
    logic [15:0] capt;
    timer_channel_pkg::run_state_t st;
    logic irq;
    logic [31:0] rdata;
  } chan_state_t;

  chan_state_t s_r;
  chan_state_t s_nxt;
  logic valid_edge;
  logic start_edge;
  logic capture_edge;
  logic [2:0] md;
  logic opt;
  logic [2:0] sts;
  logic wr;
  logic rd_setup;
  logic start_sw;
  logic stop_sw;
  logic trig;
  logic tick;
  logic down_mode;
  logic ev_toggle;
  logic ev_set;
  logic ev_clr;

  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      timer_channel_pkg::OFS_MODE, timer_channel_pkg::OFS_COMPARE,
      timer_channel_pkg::OFS_MASTER_SLAVE, timer_channel_pkg::OFS_POLARITY,
      timer_channel_pkg::OFS_OUT_VALUES, timer_channel_pkg::OFS_CONTROL,
      timer_channel_pkg::OFS_STATUS, timer_channel_pkg::OFS_CAPTURE: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] read_word(input logic [7:0] a, input chan_state_t s);
    case (a)
      timer_channel_pkg::OFS_MODE: read_word = {16'h0000, s.mode};
      timer_channel_pkg::OFS_COMPARE: read_word = {16'h0000, s.compare};
      timer_channel_pkg::OFS_MASTER_SLAVE: read_word = {30'h0, s.tom, 1'b0};
      timer_channel_pkg::OFS_POLARITY: read_word = {30'h0, s.tol, 1'b0};
      timer_channel_pkg::OFS_OUT_VALUES: read_word = {30'h0, s.tout, 1'b0};
      timer_channel_pkg::OFS_CONTROL: read_word = {29'h0, s.toe, 2'h0};
      timer_channel_pkg::OFS_STATUS: read_word = {s.cnt, 15'h0, s.st == timer_channel_pkg::ST_RUN};
      timer_channel_pkg::OFS_CAPTURE: read_word = {16'h0000, s.capt};
      default: read_word = 32'h0000_0000;
    endcase
  endfunction

  input_edge_select u_edge (
    .clk(clk),
    .rst(rst),
    .timer_input_pin(timer_input_pin),
    .edge_sel(s_r.mode[timer_channel_pkg::EDGE_LO +: 2]),
    .valid_edge(valid_edge),
    .start_edge(start_edge),
    .capture_edge(capture_edge)
  );

  assign md = s_r.mode[timer_channel_pkg::MODE_LO +: 3];
  assign opt = s_r.mode[timer_channel_pkg::MODE_OPT_BIT];
  assign sts = s_r.mode[timer_channel_pkg::STS_LO +: 3];
  assign wr = psel & penable & pwrite & is_mapped(paddr);
  assign rd_setup = psel & ~penable;
  assign start_sw = wr & (paddr == timer_channel_pkg::OFS_CONTROL) & pwdata[timer_channel_pkg::CTL_START_BIT];
  assign stop_sw = wr & (paddr == timer_channel_pkg::OFS_CONTROL) & pwdata[timer_channel_pkg::CTL_STOP_BIT];
  assign trig = start_sw | ((sts == timer_channel_pkg::STS_PIN) & start_edge);
  assign tick = (s_r.mode[timer_channel_pkg::CCS_BIT] | (md == timer_channel_pkg::MD_EVENT)) ? valid_edge : 1'b1;
  assign down_mode = (md == timer_channel_pkg::MD_INTERVAL) | (md == timer_channel_pkg::MD_EVENT) |
                     (md == timer_channel_pkg::MD_ONECOUNT);

  always_comb begin
    s_nxt = s_r;
    s_nxt.irq = 1'b0;
    ev_toggle = 1'b0;
    ev_set = 1'b0;
    ev_clr = 1'b0;
    if (rd_setup) begin
      s_nxt.rdata = read_word(paddr, s_r);
    end
    if (wr) begin
      case (paddr)
        timer_channel_pkg::OFS_MODE: s_nxt.mode = pwdata[15:0] & timer_channel_pkg::MODE_WR_MASK;
        timer_channel_pkg::OFS_COMPARE: s_nxt.compare = pwdata[15:0];
        timer_channel_pkg::OFS_MASTER_SLAVE: s_nxt.tom = pwdata[timer_channel_pkg::CH_BIT];
        timer_channel_pkg::OFS_POLARITY: s_nxt.tol = pwdata[timer_channel_pkg::CH_BIT];
        timer_channel_pkg::OFS_OUT_VALUES: begin
          if (!s_r.toe) begin
            s_nxt.tout = pwdata[timer_channel_pkg::CH_BIT];
          end
        end
        timer_channel_pkg::OFS_CONTROL: s_nxt.toe = pwdata[timer_channel_pkg::CTL_TOE_BIT];
        default: s_nxt.mode = s_r.mode;
      endcase
    end
    case (s_r.st)
      timer_channel_pkg::ST_IDLE: begin
        if (trig) begin
          s_nxt.st = timer_channel_pkg::ST_RUN;
          s_nxt.cnt = down_mode ? s_r.compare : 16'h0000;
          if (((md == timer_channel_pkg::MD_INTERVAL) | (md == timer_channel_pkg::MD_CAPTURE)) & opt) begin
            s_nxt.irq = 1'b1;
            ev_toggle = 1'b1;
          end
          if (md == timer_channel_pkg::MD_ONECOUNT) begin
            ev_set = 1'b1;
          end
        end
      end
      timer_channel_pkg::ST_RUN: begin
        if (stop_sw) begin
          s_nxt.st = timer_channel_pkg::ST_IDLE;
        end else begin
          case (md)
            timer_channel_pkg::MD_INTERVAL, timer_channel_pkg::MD_EVENT: begin
              if (tick) begin
                if (s_r.cnt == 16'h0000) begin
                  s_nxt.cnt = s_r.compare;
                  s_nxt.irq = 1'b1;
                  ev_toggle = 1'b1;
                end else begin
                  s_nxt.cnt = s_r.cnt - 16'h0001;
                end
              end
            end
            timer_channel_pkg::MD_ONECOUNT: begin
              if (trig & opt) begin
                s_nxt.cnt = s_r.compare;
                s_nxt.irq = 1'b1;
                ev_set = 1'b1;
              end else if (tick) begin
                if (s_r.cnt == 16'h0000) begin
                  s_nxt.irq = 1'b1;
                  s_nxt.st = timer_channel_pkg::ST_IDLE;
                  ev_clr = 1'b1;
                end else begin
                  s_nxt.cnt = s_r.cnt - 16'h0001;
                end
              end
            end
            timer_channel_pkg::MD_CAPTURE: begin
              if (capture_edge & (sts == timer_channel_pkg::STS_PIN)) begin
                s_nxt.capt = s_r.cnt;
                s_nxt.cnt = 16'h0000;
                s_nxt.irq = 1'b1;
              end else if (tick) begin
                s_nxt.cnt = s_r.cnt + 16'h0001;
              end
            end
            timer_channel_pkg::MD_CAPONE: begin
              if (capture_edge) begin
                s_nxt.capt = s_r.cnt;
                s_nxt.irq = 1'b1;
                s_nxt.st = timer_channel_pkg::ST_IDLE;
              end else if (tick) begin
                s_nxt.cnt = s_r.cnt + 16'h0001;
              end
            end
            default: s_nxt.st = timer_channel_pkg::ST_IDLE;
          endcase
        end
      end
      default: s_nxt.st = timer_channel_pkg::ST_IDLE;
    endcase
    if (s_r.toe) begin
      if (s_r.tom) begin
        if (ev_set) begin
          s_nxt.tout = ~s_r.tol;
        end else if (ev_clr) begin
          s_nxt.tout = s_r.tol;
        end
      end else if (ev_toggle) begin
        s_nxt.tout = ~s_r.tout;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r.mode <= timer_channel_pkg::MODE_RST;
      s_r.compare <= timer_channel_pkg::COMPARE_RST;
      s_r.tom <= 1'b0;
      s_r.tol <= 1'b0;
      s_r.toe <= 1'b0;
      s_r.tout <= timer_channel_pkg::OUT_BIT_RST;
      s_r.cnt <= 16'h0000;
      s_r.capt <= 16'h0000;
      s_r.st <= timer_channel_pkg::ST_IDLE;
      s_r.irq <= 1'b0;
      s_r.rdata <= 32'h0000_0000;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.rdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~is_mapped(paddr);
  assign timer_output = s_r.tout;
  assign channel_interrupt = s_r.irq;

  a_start_irq: assert property (@(posedge clk) disable iff (rst)
    (s_r.st == timer_channel_pkg::ST_IDLE && trig && md == 3'h0 && opt) |=> channel_interrupt)
    else $error("no start interrupt in interval mode");
  a_event_quiet: assert property (@(posedge clk) disable iff (rst)
    (s_r.st == timer_channel_pkg::ST_IDLE && trig && md == 3'h3) |=> (!channel_interrupt && $stable(timer_output)))
    else $error("event counter start not quiet");
  a_retrig_ignore: assert property (@(posedge clk) disable iff (rst)
    (s_r.st == timer_channel_pkg::ST_RUN && md == 3'h4 && !opt && trig && !stop_sw && s_r.cnt != 16'h0000)
    |=> !channel_interrupt)
    else $error("one-count retrigger not ignored");
  a_capone_quiet: assert property (@(posedge clk) disable iff (rst)
    (s_r.st == timer_channel_pkg::ST_IDLE && trig && md == 3'h6) |=> (!channel_interrupt && $stable(timer_output)))
    else $error("capture one-count start not quiet");
  a_interval_reload: assert property (@(posedge clk) disable iff (rst)
    (s_r.st == timer_channel_pkg::ST_RUN && md == 3'h0 && tick && s_r.cnt == 16'h0000 && !stop_sw && !wr)
    |=> (channel_interrupt && s_r.cnt == $past(s_r.compare)))
    else $error("interval reload wrong");
  a_down_count: assert property (@(posedge clk) disable iff (rst)
    (s_r.st == timer_channel_pkg::ST_RUN && down_mode && tick && !trig && s_r.cnt != 16'h0000 && !stop_sw)
    |=> (s_r.cnt == $past(s_r.cnt) - 16'h0001))
    else $error("counter did not count down");
  a_up_count: assert property (@(posedge clk) disable iff (rst)
    (s_r.st == timer_channel_pkg::ST_RUN && md == 3'h2 && tick && !capture_edge && !stop_sw)
    |=> (s_r.cnt == $past(s_r.cnt) + 16'h0001))
    else $error("capture counter did not count up");
  a_sw_output: assert property (@(posedge clk) disable iff (rst)
    (wr && paddr == 8'h10 && !s_r.toe) |=> (timer_output == $past(pwdata[1])))
    else $error("software output write lost");
  a_start_load: assert property (@(posedge clk) disable iff (rst)
    (s_r.st == timer_channel_pkg::ST_IDLE && trig && down_mode && !wr) |=> (s_r.cnt == $past(s_r.compare)))
    else $error("compare not loaded at start");
  a_start_silent: assert property (@(posedge clk) disable iff (rst)
    (s_r.st == timer_channel_pkg::ST_IDLE && trig && !opt &&
     (md == timer_channel_pkg::MD_INTERVAL || md == timer_channel_pkg::MD_CAPTURE) &&
     !(wr && paddr == timer_channel_pkg::OFS_OUT_VALUES))
    |=> (!channel_interrupt && $stable(timer_output)))
    else $error("start interrupt without option");
  a_capture_take: assert property (@(posedge clk) disable iff (rst)
    (s_r.st == timer_channel_pkg::ST_RUN && md == timer_channel_pkg::MD_CAPTURE && capture_edge &&
     sts == timer_channel_pkg::STS_PIN && !stop_sw)
    |=> (channel_interrupt && s_r.capt == $past(s_r.cnt) && s_r.cnt == 16'h0000))
    else $error("capture not taken");
  a_capone_end: assert property (@(posedge clk) disable iff (rst)
    (s_r.st == timer_channel_pkg::ST_RUN && md == timer_channel_pkg::MD_CAPONE && capture_edge && !stop_sw)
    |=> (channel_interrupt && s_r.st == timer_channel_pkg::ST_IDLE && s_r.capt == $past(s_r.cnt)))
    else $error("width capture did not end");
  a_retrig_restart: assert property (@(posedge clk) disable iff (rst)
    (s_r.st == timer_channel_pkg::ST_RUN && md == timer_channel_pkg::MD_ONECOUNT && opt && trig && !stop_sw)
    |=> (channel_interrupt && s_r.cnt == $past(s_r.compare)))
    else $error("one-count retrigger not taken");
  a_master_toggle: assert property (@(posedge clk) disable iff (rst)
    (s_r.st == timer_channel_pkg::ST_RUN && md == timer_channel_pkg::MD_INTERVAL && tick &&
     s_r.cnt == 16'h0000 && !stop_sw && s_r.toe && !s_r.tom)
    |=> (timer_output != $past(timer_output)))
    else $error("master output did not toggle");
  a_slave_level: assert property (@(posedge clk) disable iff (rst)
    (s_r.st == timer_channel_pkg::ST_IDLE && trig && md == timer_channel_pkg::MD_ONECOUNT && s_r.toe && s_r.tom)
    |=> (timer_output == !$past(s_r.tol)))
    else $error("slave output level wrong at start");
  a_out_readback: assert property (@(posedge clk) disable iff (rst)
    (rd_setup && paddr == timer_channel_pkg::OFS_OUT_VALUES)
    |=> (prdata == {30'h0, $past(s_r.tout), 1'b0}))
    else $error("output value read back wrong");
  a_soft_only: assert property (@(posedge clk) disable iff (rst)
    (s_r.st == timer_channel_pkg::ST_IDLE && sts == timer_channel_pkg::STS_SOFT && !start_sw)
    |=> (s_r.st == timer_channel_pkg::ST_IDLE))
    else $error("started without software trigger");
  a_pin_start: assert property (@(posedge clk) disable iff (rst)
    (s_r.st == timer_channel_pkg::ST_IDLE && sts == timer_channel_pkg::STS_PIN && start_edge)
    |=> (s_r.st == timer_channel_pkg::ST_RUN))
    else $error("pin edge did not start");
  a_out_locked: assert property (@(posedge clk) disable iff (rst)
    (wr && paddr == timer_channel_pkg::OFS_OUT_VALUES && s_r.toe && s_r.st == timer_channel_pkg::ST_IDLE && !trig)
    |=> $stable(timer_output))
    else $error("output write not ignored");
endmodule // timer_channel
`default_nettype wire

// ### timer_channel_pkg.sv
package timer_channel_pkg;
  // Register byte offsets on the APB bus
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_COMPARE = 8'h04;
  localparam logic [7:0] OFS_MASTER_SLAVE = 8'h08;
  localparam logic [7:0] OFS_POLARITY = 8'h0C;
  localparam logic [7:0] OFS_OUT_VALUES = 8'h10;
  localparam logic [7:0] OFS_CONTROL = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_CAPTURE = 8'h1C;

  // Field positions in channel_mode_config
  localparam int MODE_OPT_BIT = 0;
  localparam int MODE_LO = 1;
  localparam int EDGE_LO = 6;
  localparam int STS_LO = 8;
  localparam int CCS_BIT = 12;
  localparam logic [15:0] MODE_WR_MASK = 16'hD7CF;

  // Channel bit in the output registers
  localparam int CH_BIT = 1;

  // Control register bits
  localparam int CTL_START_BIT = 0;
  localparam int CTL_STOP_BIT = 1;
  localparam int CTL_TOE_BIT = 2;

  // Reset values
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] COMPARE_RST = 16'h0000;
  localparam logic OUT_BIT_RST = 1'b0;

  // Operating mode codes
  localparam logic [2:0] MD_INTERVAL = 3'h0;
  localparam logic [2:0] MD_CAPTURE = 3'h2;
  localparam logic [2:0] MD_EVENT = 3'h3;
  localparam logic [2:0] MD_ONECOUNT = 3'h4;
  localparam logic [2:0] MD_CAPONE = 3'h6;

  // Edge selection codes
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_LOW_W = 2'h2;
  localparam logic [1:0] EDGE_HIGH_W = 2'h3;

  // Trigger source codes
  localparam logic [2:0] STS_SOFT = 3'h0;
  localparam logic [2:0] STS_PIN = 3'h1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } run_state_t;
endpackage

// ### input_edge_select.sv
`timescale 1ns/1ns
`default_nettype none
module input_edge_select (
  input wire logic clk,
  input wire logic rst,
  input wire logic timer_input_pin,
  input wire logic [1:0] edge_sel,
  output logic valid_edge,
  output logic start_edge,
  output logic capture_edge
);
  typedef struct packed {
    logic prev;
  } edge_state_t;

  edge_state_t s_r;
  edge_state_t s_nxt;
  logic rise;
  logic fall;

  always_comb begin
    s_nxt = s_r;
    s_nxt.prev = timer_input_pin;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rise = timer_input_pin & ~s_r.prev;
  assign fall = ~timer_input_pin & s_r.prev;

  always_comb begin
    case (edge_sel)
      timer_channel_pkg::EDGE_FALL: begin
        valid_edge = fall;
        start_edge = fall;
        capture_edge = fall;
      end
      timer_channel_pkg::EDGE_RISE: begin
        valid_edge = rise;
        start_edge = rise;
        capture_edge = rise;
      end
      timer_channel_pkg::EDGE_LOW_W: begin
        valid_edge = rise | fall;
        start_edge = fall;
        capture_edge = rise;
      end
      default: begin
        valid_edge = rise | fall;
        start_edge = rise;
        capture_edge = fall;
      end
    endcase
  end

  a_fall_valid: assert property (@(posedge clk) disable iff (rst)
    (edge_sel == 2'h0 && s_r.prev && !timer_input_pin) |-> (valid_edge && !start_edge == 1'b0))
    else $error("falling edge not valid");
  a_low_width: assert property (@(posedge clk) disable iff (rst)
    (edge_sel == 2'h2 && !s_r.prev && timer_input_pin) |-> (capture_edge && !start_edge))
    else $error("low width capture edge wrong");
  a_high_width: assert property (@(posedge clk) disable iff (rst)
    (edge_sel == 2'h3 && !s_r.prev && timer_input_pin) |-> (start_edge && !capture_edge))
    else $error("high width start edge wrong");
endmodule // input_edge_select
`default_nettype wire

// ### pin_source.sv
`timescale 1ns/1ns
`default_nettype none
module pin_source (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [7:0] hi_len,
  input wire logic [7:0] lo_len,
  output logic timer_input_pin
);
  logic [7:0] cnt_r;
  // Idle high between bursts, a burst opens with its low phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 8'h00;
      timer_input_pin <= 1'b1;
    end else if (!run) begin
      cnt_r <= 8'h00;
      timer_input_pin <= 1'b1;
    end else if (cnt_r == 8'h00) begin
      timer_input_pin <= ~timer_input_pin;
      cnt_r <= (timer_input_pin ? lo_len : hi_len) - 8'h01;
    end else begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
endmodule // pin_source
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q, wl, wh;
  logic pready, pslverr, pin, tout, irq, err;
  logic run = 1'b0;
  int bad_count = 0;
  int samples_checked = 0;

  always #20 clk = ~clk;

  timer_channel u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_input_pin(pin),
    .timer_output(tout), .channel_interrupt(irq));
  pin_source u_src (.clk(clk), .rst(rst), .run(run), .hi_len(8'h06), .lo_len(8'h0A), .timer_input_pin(pin));

  task complete_run;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      bad_count++;
      complete_run;
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(q, exp);
  endtask

  task wait_irq(output int n);
    n = 0;
    @(negedge clk);
    while (irq !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (irq !== 1'b1) begin
      bad_count++;
      complete_run;
    end
  endtask

  task count_irq(input int cyc, output int c);
    c = 0;
    repeat (cyc) begin
      @(negedge clk);
      if (irq === 1'b1) c++;
    end
  endtask

  function automatic logic [31:0] cfg(logic [2:0] sts, logic [1:0] e, logic [2:0] md, logic opt);
    cfg = {19'h0, 1'b0, 1'b0, sts, e, 2'b00, md, opt};
  endfunction

  task t_regs;
    rd(timer_channel_pkg::OFS_MODE, 32'h0);
    rd(timer_channel_pkg::OFS_OUT_VALUES, 32'h0);
    wr(timer_channel_pkg::OFS_MODE, 32'hFFFF);
    rd(timer_channel_pkg::OFS_MODE, {16'h0, timer_channel_pkg::MODE_WR_MASK});
    wr(timer_channel_pkg::OFS_COMPARE, 32'hA5C3);
    rd(timer_channel_pkg::OFS_COMPARE, 32'hA5C3);
    wr(timer_channel_pkg::OFS_MASTER_SLAVE, 32'hFFFF);
    rd(timer_channel_pkg::OFS_MASTER_SLAVE, 32'h2);
    wr(timer_channel_pkg::OFS_POLARITY, 32'hFFFF);
    rd(timer_channel_pkg::OFS_POLARITY, 32'h2);
    rd(8'h20, 32'h0);
    check({31'h0, err}, 32'h1);
    $display("test registers done");
  endtask

  task t_output;
    wr(timer_channel_pkg::OFS_MASTER_SLAVE, 32'h0);
    wr(timer_channel_pkg::OFS_POLARITY, 32'h0);
    wr(timer_channel_pkg::OFS_OUT_VALUES, 32'h2);
    @(negedge clk);
    check({31'h0, tout}, 32'h1);
    rd(timer_channel_pkg::OFS_OUT_VALUES, 32'h2);
    wr(timer_channel_pkg::OFS_CONTROL, 32'h4);
    wr(timer_channel_pkg::OFS_OUT_VALUES, 32'h0);
    rd(timer_channel_pkg::OFS_OUT_VALUES, 32'h2);
    wr(timer_channel_pkg::OFS_CONTROL, 32'h0);
    wr(timer_channel_pkg::OFS_OUT_VALUES, 32'h0);
    $display("test output done");
  endtask

  task t_interval(input logic opt);
    int n;
    logic t0;
    wr(timer_channel_pkg::OFS_COMPARE, 32'h4);
    wr(timer_channel_pkg::OFS_MODE, cfg(3'h0, 2'h0, timer_channel_pkg::MD_INTERVAL, opt));
    wr(timer_channel_pkg::OFS_CONTROL, 32'h4);
    wr(timer_channel_pkg::OFS_CONTROL, 32'h5);
    @(negedge clk);
    check({30'h0, tout, irq}, {30'h0, opt, opt});
    wait_irq(n);
    t0 = tout;
    wait_irq(n);
    check(n, 32'h4);
    check({31'h0, tout}, {31'h0, ~t0});
    wr(timer_channel_pkg::OFS_CONTROL, 32'h2);
    wr(timer_channel_pkg::OFS_OUT_VALUES, 32'h0);
    $display("test interval done");
  endtask

  task t_onecount(input logic pol);
    int c;
    int n;
    wr(timer_channel_pkg::OFS_MASTER_SLAVE, 32'h2);
    wr(timer_channel_pkg::OFS_POLARITY, {30'h0, pol, 1'b0});
    wr(timer_channel_pkg::OFS_COMPARE, 32'hA);
    wr(timer_channel_pkg::OFS_MODE, cfg(3'h0, 2'h0, timer_channel_pkg::MD_ONECOUNT, pol));
    wr(timer_channel_pkg::OFS_CONTROL, 32'h4);
    wr(timer_channel_pkg::OFS_CONTROL, 32'h5);
    @(negedge clk);
    check({31'h0, tout}, {31'h0, ~pol});
    wr(timer_channel_pkg::OFS_CONTROL, 32'h5);
    count_irq(2, c);
    check(c, {31'h0, pol});
    wait_irq(n);
    @(negedge clk);
    check({31'h0, tout}, {31'h0, pol});
    wr(timer_channel_pkg::OFS_CONTROL, 32'h2);
    $display("test one count done");
  endtask

  task t_event(input logic e);
    int n;
    wr(timer_channel_pkg::OFS_COMPARE, 32'h1);
    wr(timer_channel_pkg::OFS_MODE, cfg(3'h0, {1'b0, e}, timer_channel_pkg::MD_EVENT, 1'b0));
    wr(timer_channel_pkg::OFS_CONTROL, 32'h1);
    run <= 1'b1;
    wait_irq(n);
    wait_irq(n);
    check(n, 32'h1F);
    check({31'h0, pin}, {31'h0, e});
    @(posedge clk);
    run <= 1'b0;
    wr(timer_channel_pkg::OFS_CONTROL, 32'h2);
    $display("test event done");
  endtask

  task t_capone(input logic [1:0] e, output logic [31:0] w);
    int n;
    wr(timer_channel_pkg::OFS_MODE, cfg(timer_channel_pkg::STS_PIN, e, timer_channel_pkg::MD_CAPONE, 1'b0));
    run <= 1'b1;
    wait_irq(n);
    check({31'h0, pin}, {31'h0, ~e[0]});
    @(posedge clk);
    run <= 1'b0;
    apb(1'b0, timer_channel_pkg::OFS_CAPTURE, 32'h0);
    w = q;
    wr(timer_channel_pkg::OFS_CONTROL, 32'h2);
    $display("test width done");
  endtask

  task t_capture;
    int c;
    int n;
    wr(timer_channel_pkg::OFS_MODE, cfg(timer_channel_pkg::STS_SOFT, 2'h1, timer_channel_pkg::MD_CAPTURE, 1'b0));
    run <= 1'b1;
    count_irq(40, c);
    check(c, 32'h0);
    apb(1'b0, timer_channel_pkg::OFS_STATUS, 32'h0);
    check({31'h0, q[0]}, 32'h0);
    wr(timer_channel_pkg::OFS_MODE, cfg(timer_channel_pkg::STS_PIN, 2'h1, timer_channel_pkg::MD_CAPTURE, 1'b0));
    wr(timer_channel_pkg::OFS_CONTROL, 32'h1);
    wait_irq(n);
    wait_irq(n);
    check(n, 32'hF);
    @(posedge clk);
    run <= 1'b0;
    wr(timer_channel_pkg::OFS_CONTROL, 32'h2);
    $display("test capture done");
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_output;
    t_interval(1'b0);
    t_interval(1'b1);
    t_onecount(1'b0);
    t_onecount(1'b1);
    t_event(1'b0);
    t_event(1'b1);
    t_capone(2'h2, wl);
    t_capone(2'h3, wh);
    check({31'h0, wl > wh}, 32'h1);
    t_capture;
    complete_run;
  end
endmodule // testbench
`default_nettype wire
